// ==== flag_consts.vh ====
`ifndef FLAG_CONSTS_VH
`define FLAG_CONSTS_VH

// clock rate and counter width
`define CLK_MHZ             100
`define CNT_W               24

// qualification filter on supply and current monitors
`define FILTER_US           100
`define FILTER_CYCLES       (`FILTER_US * `CLK_MHZ)

// reset pin low pulses shorter than this count as short
`define RST_SHORT_MS        100
`define RST_SHORT_CYCLES    (`RST_SHORT_MS * 1000 * `CLK_MHZ)

// dominant timeout period, plain default in microseconds
`define DOM_TIMEOUT_US      1000
`define DOM_TIMEOUT_CYCLES  (`DOM_TIMEOUT_US * `CLK_MHZ)

// synchroniser vector layout
`define SYNC_W              18
`define SYNC_INIT           18'h00200
`define BIT_AUX_UV          0
`define BIT_AUX_OC          1
`define BIT_TSUP_THERMAL    2
`define BIT_TSUP_UV         3
`define BIT_TSUP_OC         4
`define BIT_SENSE_LOW       5
`define BIT_SUP_UV          6
`define BIT_MAIN_OC         7
`define BIT_MAIN_THERMAL    8
`define BIT_RST_PIN_N       9
`define BIT_BATFAIL         10
`define BIT_CAN_WAKE        11
`define BIT_CAN_OVERTEMP    12
`define BIT_RXD_LOW         13
`define BIT_RXD_HIGH        14
`define BIT_TXD_DOM         15
`define BIT_BUS_DOM         16
`define BIT_SPARE           17

`endif

// ==== flag_latch.v ====
`timescale 1ns/1ps
`include "flag_consts.vh"

module flag_latch #(
    parameter          CW     = `CNT_W,
    parameter [CW-1:0] FILTER = {CW{1'b0}}
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire ce_i,
    input  wire cond_i,
    input  wire event_i,
    input  wire read_i,
    output wire flag_o
);

    reg [CW-1:0] cnt_reg;
    reg [CW-1:0] cnt_next;
    reg          flag_reg;
    reg          flag_next;
    wire         qualified;

    // any dropout restarts the count: only unbroken conditions qualify
    always @* begin
        if (!cond_i) begin
            cnt_next = {CW{1'b0}};
        end else if (cnt_reg != FILTER) begin
            cnt_next = cnt_reg + {{(CW-1){1'b0}}, 1'b1};
        end else begin
            cnt_next = cnt_reg;
        end
    end

    assign qualified = cond_i && (cnt_reg == FILTER);

    // set wins over clear; a read clears only once the cause is gone
    always @* begin
        if (qualified || event_i) begin
            flag_next = 1'b1;
        end else if (read_i && !cond_i) begin
            flag_next = 1'b0;
        end else begin
            flag_next = flag_reg;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg  <= {CW{1'b0}};
            flag_reg <= 1'b0;
        end else if (ce_i) begin
            cnt_reg  <= cnt_next;
            flag_reg <= flag_next;
        end
    end

    assign flag_o = flag_reg;

endmodule // flag_latch

// ==== supply_can_diag_flags.v ====
`timescale 1ns/1ps
`include "flag_consts.vh"

module supply_can_diag_flags #(
    parameter FILTER_CYCLES      = `FILTER_CYCLES,
    parameter RST_SHORT_CYCLES   = `RST_SHORT_CYCLES,
    parameter DOM_TIMEOUT_CYCLES = `DOM_TIMEOUT_CYCLES
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire ce_i,
    // monitor levels from the analog side, asynchronous
    input  wire aux_undervoltage_i,
    input  wire aux_overcurrent_i,
    input  wire transceiver_supply_thermal_i,
    input  wire transceiver_supply_undervoltage_i,
    input  wire transceiver_supply_overcurrent_i,
    input  wire sense_input_low_i,
    input  wire battery_undervoltage_i,
    input  wire main_reg_overcurrent_i,
    input  wire main_reg_overcurrent_lp_i,
    input  wire main_reg_thermal_off_i,
    input  wire reset_pin_n_i,
    input  wire battery_fail_i,
    input  wire can_wake_i,
    input  wire can_overtemp_i,
    input  wire rxd_stuck_low_i,
    input  wire rxd_stuck_high_i,
    input  wire txd_stuck_dominant_i,
    input  wire bus_dominant_i,
    // same-domain mode and read strobes
    input  wire normal_mode_i,
    input  wire lowpower_vddon_mode_i,
    input  wire supply_flags_read_i,
    input  wire can_flags_read_i,
    // sticky flags
    output wire aux_undervoltage_flag_o,
    output wire aux_overcurrent_flag_o,
    output wire transceiver_supply_thermal_flag_o,
    output wire transceiver_supply_undervoltage_flag_o,
    output wire transceiver_supply_overcurrent_flag_o,
    output wire sense_input_low_flag_o,
    output wire battery_undervoltage_flag_o,
    output wire main_reg_overcurrent_normal_flag_o,
    output wire main_reg_thermal_flag_o,
    output wire short_reset_pulse_flag_o,
    output wire battery_fail_flag_o,
    output wire main_reg_overcurrent_lowpower_flag_o,
    output wire can_wake_flag_o,
    output wire can_overtemp_flag_o,
    output wire rxd_stuck_low_flag_o,
    output wire rxd_stuck_high_flag_o,
    output wire txd_stuck_dominant_flag_o,
    output wire bus_dominant_clamp_flag_o
);

    localparam              CW         = `CNT_W;
    localparam [CW-1:0]     FILTER     = FILTER_CYCLES[CW-1:0];
    localparam [CW-1:0]     RST_SHORT  = RST_SHORT_CYCLES[CW-1:0];
    localparam [CW-1:0]     DOM_LIMIT  = DOM_TIMEOUT_CYCLES[CW-1:0];
    localparam [CW-1:0]     NO_FILTER  = {CW{1'b0}};
    localparam [CW-1:0]     ONE        = {{(CW-1){1'b0}}, 1'b1};

    wire [`SYNC_W-1:0] raw;
    reg  [`SYNC_W-1:0] s1_reg;
    reg  [`SYNC_W-1:0] s2_reg;

    reg          wake_prev_reg;
    reg          rst_pin_prev_reg;
    reg [CW-1:0] rst_low_cnt_reg;
    reg [CW-1:0] rst_low_cnt_next;
    reg          short_pulse_reg;
    reg          short_pulse_next;
    reg [CW-1:0] dom_cnt_reg;
    reg [CW-1:0] dom_cnt_next;
    reg          clamp_reg;
    reg          clamp_next;

    wire rst_pin_low;
    wire wake_edge;
    wire oc_normal;
    wire oc_lowpower;

    assign raw[`BIT_AUX_UV]       = aux_undervoltage_i;
    assign raw[`BIT_AUX_OC]       = aux_overcurrent_i;
    assign raw[`BIT_TSUP_THERMAL] = transceiver_supply_thermal_i;
    assign raw[`BIT_TSUP_UV]      = transceiver_supply_undervoltage_i;
    assign raw[`BIT_TSUP_OC]      = transceiver_supply_overcurrent_i;
    assign raw[`BIT_SENSE_LOW]    = sense_input_low_i;
    assign raw[`BIT_SUP_UV]       = battery_undervoltage_i;
    assign raw[`BIT_MAIN_OC]      = main_reg_overcurrent_i;
    assign raw[`BIT_MAIN_THERMAL] = main_reg_thermal_off_i;
    assign raw[`BIT_RST_PIN_N]    = reset_pin_n_i;
    assign raw[`BIT_BATFAIL]      = battery_fail_i;
    assign raw[`BIT_CAN_WAKE]     = can_wake_i;
    assign raw[`BIT_CAN_OVERTEMP] = can_overtemp_i;
    assign raw[`BIT_RXD_LOW]      = rxd_stuck_low_i;
    assign raw[`BIT_RXD_HIGH]     = rxd_stuck_high_i;
    assign raw[`BIT_TXD_DOM]      = txd_stuck_dominant_i;
    assign raw[`BIT_BUS_DOM]      = bus_dominant_i;
    assign raw[`BIT_SPARE]        = main_reg_overcurrent_lp_i;

    // reset pin resets high so release does not look like a short pulse
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_reg <= `SYNC_INIT;
            s2_reg <= `SYNC_INIT;
        end else if (ce_i) begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
        end
    end

    assign rst_pin_low = !s2_reg[`BIT_RST_PIN_N];
    assign wake_edge   = s2_reg[`BIT_CAN_WAKE] && !wake_prev_reg;
    // mode gating: each current limit only counts in its own mode
    assign oc_normal   = s2_reg[`BIT_MAIN_OC] && normal_mode_i;
    assign oc_lowpower = s2_reg[`BIT_SPARE] && lowpower_vddon_mode_i;

    // measure reset pin low time, saturating at the short limit
    always @* begin
        rst_low_cnt_next = rst_low_cnt_reg;
        short_pulse_next = 1'b0;
        if (rst_pin_low) begin
            if (rst_low_cnt_reg != RST_SHORT) begin
                rst_low_cnt_next = rst_low_cnt_reg + ONE;
            end
        end else begin
            rst_low_cnt_next = {CW{1'b0}};
            if (rst_pin_prev_reg && (rst_low_cnt_reg < RST_SHORT)) begin
                short_pulse_next = 1'b1;
            end
        end
    end

    // bus dominant watchdog; clamp drops as soon as the bus releases
    always @* begin
        if (!s2_reg[`BIT_BUS_DOM]) begin
            dom_cnt_next = {CW{1'b0}};
            clamp_next   = 1'b0;
        end else if (dom_cnt_reg != DOM_LIMIT) begin
            dom_cnt_next = dom_cnt_reg + ONE;
            clamp_next   = 1'b0;
        end else begin
            dom_cnt_next = dom_cnt_reg;
            clamp_next   = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_prev_reg    <= 1'b0;
            rst_pin_prev_reg <= 1'b0;
            rst_low_cnt_reg  <= {CW{1'b0}};
            short_pulse_reg  <= 1'b0;
            dom_cnt_reg      <= {CW{1'b0}};
            clamp_reg        <= 1'b0;
        end else if (ce_i) begin
            wake_prev_reg    <= s2_reg[`BIT_CAN_WAKE];
            rst_pin_prev_reg <= rst_pin_low;
            rst_low_cnt_reg  <= rst_low_cnt_next;
            short_pulse_reg  <= short_pulse_next;
            dom_cnt_reg      <= dom_cnt_next;
            clamp_reg        <= clamp_next;
        end
    end

    flag_latch #(.CW(CW), .FILTER(FILTER)) u_aux_uv (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_AUX_UV]),
        .event_i (1'b0),
        .read_i  (supply_flags_read_i),
        .flag_o  (aux_undervoltage_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(FILTER)) u_aux_oc (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_AUX_OC]),
        .event_i (1'b0),
        .read_i  (supply_flags_read_i),
        .flag_o  (aux_overcurrent_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(NO_FILTER)) u_tsup_thermal (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_TSUP_THERMAL]),
        .event_i (1'b0),
        .read_i  (supply_flags_read_i),
        .flag_o  (transceiver_supply_thermal_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(FILTER)) u_tsup_uv (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_TSUP_UV]),
        .event_i (1'b0),
        .read_i  (supply_flags_read_i),
        .flag_o  (transceiver_supply_undervoltage_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(FILTER)) u_tsup_oc (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_TSUP_OC]),
        .event_i (1'b0),
        .read_i  (supply_flags_read_i),
        .flag_o  (transceiver_supply_overcurrent_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(FILTER)) u_sense_low (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_SENSE_LOW]),
        .event_i (1'b0),
        .read_i  (supply_flags_read_i),
        .flag_o  (sense_input_low_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(FILTER)) u_sup_uv (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_SUP_UV]),
        .event_i (1'b0),
        .read_i  (supply_flags_read_i),
        .flag_o  (battery_undervoltage_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(FILTER)) u_main_oc_normal (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (oc_normal),
        .event_i (1'b0),
        .read_i  (supply_flags_read_i),
        .flag_o  (main_reg_overcurrent_normal_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(NO_FILTER)) u_main_thermal (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_MAIN_THERMAL]),
        .event_i (1'b0),
        .read_i  (supply_flags_read_i),
        .flag_o  (main_reg_thermal_flag_o)
    );

    // pin low below the short limit holds off the clear but never sets; only the pulse end sets
    flag_latch #(.CW(CW), .FILTER(RST_SHORT)) u_short_reset (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (rst_pin_low && (rst_low_cnt_reg != RST_SHORT)),
        .event_i (short_pulse_reg),
        .read_i  (supply_flags_read_i),
        .flag_o  (short_reset_pulse_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(NO_FILTER)) u_batfail (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_BATFAIL]),
        .event_i (1'b0),
        .read_i  (supply_flags_read_i),
        .flag_o  (battery_fail_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(FILTER)) u_main_oc_lp (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (oc_lowpower),
        .event_i (1'b0),
        .read_i  (supply_flags_read_i),
        .flag_o  (main_reg_overcurrent_lowpower_flag_o)
    );

    // wake has no recovery condition, so a read alone clears it
    flag_latch #(.CW(CW), .FILTER(NO_FILTER)) u_can_wake (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (1'b0),
        .event_i (wake_edge),
        .read_i  (can_flags_read_i),
        .flag_o  (can_wake_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(NO_FILTER)) u_can_overtemp (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_CAN_OVERTEMP]),
        .event_i (1'b0),
        .read_i  (can_flags_read_i),
        .flag_o  (can_overtemp_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(NO_FILTER)) u_rxd_low (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_RXD_LOW]),
        .event_i (1'b0),
        .read_i  (can_flags_read_i),
        .flag_o  (rxd_stuck_low_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(NO_FILTER)) u_rxd_high (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_RXD_HIGH]),
        .event_i (1'b0),
        .read_i  (can_flags_read_i),
        .flag_o  (rxd_stuck_high_flag_o)
    );

    flag_latch #(.CW(CW), .FILTER(NO_FILTER)) u_txd_dom (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (s2_reg[`BIT_TXD_DOM]),
        .event_i (1'b0),
        .read_i  (can_flags_read_i),
        .flag_o  (txd_stuck_dominant_flag_o)
    );

    // clear also needs the bus itself released, not just the clamp
    flag_latch #(.CW(CW), .FILTER(NO_FILTER)) u_bus_clamp (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cond_i  (clamp_reg),
        .event_i (1'b0),
        .read_i  (can_flags_read_i && !s2_reg[`BIT_BUS_DOM]),
        .flag_o  (bus_dominant_clamp_flag_o)
    );

endmodule // supply_can_diag_flags

// ==== supply_can_diag_flags_properties.sv ====
`timescale 1ns/1ps
module supply_can_diag_flags_chk #(
    parameter FILTER_CYCLES      = 20,
    parameter DOM_TIMEOUT_CYCLES = 30
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire aux_undervoltage_i,
    input wire aux_overcurrent_i,
    input wire transceiver_supply_thermal_i,
    input wire battery_fail_i,
    input wire txd_stuck_dominant_i,
    input wire can_wake_i,
    input wire bus_dominant_i,
    input wire can_flags_read_i,
    input wire aux_undervoltage_flag_o,
    input wire aux_overcurrent_flag_o,
    input wire transceiver_supply_thermal_flag_o,
    input wire battery_fail_flag_o,
    input wire txd_stuck_dominant_flag_o,
    input wire can_wake_flag_o,
    input wire bus_dominant_clamp_flag_o
);
    int oc_run;
    int dom_run;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // frozen with the design while ce is low
    always @(posedge clk_i) begin
        if (rst_i) begin
            oc_run  <= 0;
            dom_run <= 0;
        end else if (ce_i) begin
            oc_run  <= aux_overcurrent_i ? oc_run + 1 : 0;
            dom_run <= bus_dominant_i ? dom_run + 1 : 0;
        end
    end

    AST_RESET_CLEARS: assert property (disable iff (1'b0) rst_i && ce_i |=>
        !(aux_overcurrent_flag_o || can_wake_flag_o || bus_dominant_clamp_flag_o))
        else $error("flag set after reset");
    AST_TSUP_THERMAL_SET: assert property (
        (transceiver_supply_thermal_i && ce_i) [*3] |=> transceiver_supply_thermal_flag_o)
        else $error("thermal flag late");
    AST_BATFAIL_SET: assert property (
        (battery_fail_i && ce_i) [*3] |=> battery_fail_flag_o)
        else $error("battery fail flag late");
    AST_TXD_SET: assert property (
        (txd_stuck_dominant_i && ce_i) [*3] |=> txd_stuck_dominant_flag_o)
        else $error("transmit pin flag late");
    // two depths allowed: the count may be compared before or after its register
    AST_OC_FILTER_MIN: assert property (
        $rose(aux_overcurrent_flag_o) |->
        $past(oc_run, 2) >= FILTER_CYCLES || $past(oc_run, 3) >= FILTER_CYCLES)
        else $error("overcurrent flag before filter expired");
    AST_OC_FILTER_SET: assert property (
        oc_run == FILTER_CYCLES + 4 |-> aux_overcurrent_flag_o)
        else $error("overcurrent flag missing");
    AST_CLAMP_MIN: assert property (
        $rose(bus_dominant_clamp_flag_o) |-> $past(dom_run, 2) > DOM_TIMEOUT_CYCLES ||
        $past(dom_run, 3) > DOM_TIMEOUT_CYCLES || $past(dom_run, 4) > DOM_TIMEOUT_CYCLES)
        else $error("clamp flag before timeout");
    AST_WAKE_SET: assert property (
        $rose(can_wake_flag_o) |-> $past(can_wake_i, 3) || $past(can_wake_i, 4))
        else $error("wake flag without wake");
    AST_WAKE_CLEAR: assert property (
        $fell(can_wake_flag_o) && !$past(rst_i) |-> $past(can_flags_read_i))
        else $error("wake flag fell without read");
    AST_UV_HELD: assert property (
        $fell(aux_undervoltage_flag_o) && !$past(rst_i) |->
        !$past(aux_undervoltage_i, 2) || !$past(aux_undervoltage_i, 3))
        else $error("undervoltage flag cleared while present");

    COV_OC: cover property ($rose(aux_overcurrent_flag_o));
    COV_CLAMP: cover property ($rose(bus_dominant_clamp_flag_o));
    COV_WAKE_CLEAR: cover property ($fell(can_wake_flag_o));
endmodule // supply_can_diag_flags_chk

bind supply_can_diag_flags supply_can_diag_flags_chk #(
    .FILTER_CYCLES(FILTER_CYCLES), .DOM_TIMEOUT_CYCLES(DOM_TIMEOUT_CYCLES)
) u_chk (
    .clk_i                             (clk_i),
    .rst_i                             (rst_i),
    .ce_i                              (ce_i),
    .aux_undervoltage_i                (aux_undervoltage_i),
    .aux_overcurrent_i                 (aux_overcurrent_i),
    .transceiver_supply_thermal_i      (transceiver_supply_thermal_i),
    .battery_fail_i                    (battery_fail_i),
    .txd_stuck_dominant_i              (txd_stuck_dominant_i),
    .can_wake_i                        (can_wake_i),
    .bus_dominant_i                    (bus_dominant_i),
    .can_flags_read_i                  (can_flags_read_i),
    .aux_undervoltage_flag_o           (aux_undervoltage_flag_o),
    .aux_overcurrent_flag_o            (aux_overcurrent_flag_o),
    .transceiver_supply_thermal_flag_o (transceiver_supply_thermal_flag_o),
    .battery_fail_flag_o               (battery_fail_flag_o),
    .txd_stuck_dominant_flag_o         (txd_stuck_dominant_flag_o),
    .can_wake_flag_o                   (can_wake_flag_o),
    .bus_dominant_clamp_flag_o         (bus_dominant_clamp_flag_o)
);

// ==== flag_host.sv ====
`timescale 1ns/1ps
module flag_host (
    input  wire        clk_i,
    input  wire [17:0] flags_i,
    output reg         supply_rd_o,
    output reg         can_rd_o
);
    initial begin
        supply_rd_o = 1'b0;
        can_rd_o    = 1'b0;
    end

    // word is taken at the strobe edge, before the clear lands
    task automatic read_word(input bit can, output logic [17:0] word);
        @(posedge clk_i);
        if (can)
            can_rd_o <= 1'b1;
        else
            supply_rd_o <= 1'b1;
        @(posedge clk_i);
        word = can ? {flags_i[17:12], 12'h000} : {6'h00, flags_i[11:0]};
        supply_rd_o <= 1'b0;
        can_rd_o    <= 1'b0;
    endtask
endmodule // flag_host

// ==== supply_can_diag_flags_tb.sv ====
`timescale 1ns/1ps
module supply_can_diag_flags_tb;
    localparam int F = 20;
    localparam int R = 50;
    localparam int D = 30;
    logic        clk_i;
    logic        rst_i;
    logic        ce;
    logic [17:0] mon;
    logic        norm;
    logic        lpm;
    logic [17:0] exp_f;
    logic [17:0] word;
    wire  [17:0] flags;
    wire         srd;
    wire         crd;
    int          n_fail;
    int          checked;
    int          filt[8] = '{0, 1, 3, 4, 5, 6, 7, 11};
    int          dir[7] = '{2, 8, 10, 13, 14, 15, 16};

    supply_can_diag_flags #(
        .FILTER_CYCLES(F), .RST_SHORT_CYCLES(R), .DOM_TIMEOUT_CYCLES(D)
    ) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .aux_undervoltage_i(mon[0]), .aux_overcurrent_i(mon[1]),
        .transceiver_supply_thermal_i(mon[2]),
        .transceiver_supply_undervoltage_i(mon[3]),
        .transceiver_supply_overcurrent_i(mon[4]), .sense_input_low_i(mon[5]),
        .battery_undervoltage_i(mon[6]), .main_reg_overcurrent_i(mon[7]),
        .main_reg_thermal_off_i(mon[8]), .reset_pin_n_i(!mon[9]),
        .battery_fail_i(mon[10]), .main_reg_overcurrent_lp_i(mon[11]),
        .can_wake_i(mon[12]), .can_overtemp_i(mon[13]), .rxd_stuck_low_i(mon[14]),
        .rxd_stuck_high_i(mon[15]), .txd_stuck_dominant_i(mon[16]),
        .bus_dominant_i(mon[17]), .normal_mode_i(norm), .lowpower_vddon_mode_i(lpm),
        .supply_flags_read_i(srd), .can_flags_read_i(crd),
        .aux_undervoltage_flag_o(flags[0]), .aux_overcurrent_flag_o(flags[1]),
        .transceiver_supply_thermal_flag_o(flags[2]),
        .transceiver_supply_undervoltage_flag_o(flags[3]),
        .transceiver_supply_overcurrent_flag_o(flags[4]),
        .sense_input_low_flag_o(flags[5]), .battery_undervoltage_flag_o(flags[6]),
        .main_reg_overcurrent_normal_flag_o(flags[7]), .main_reg_thermal_flag_o(flags[8]),
        .short_reset_pulse_flag_o(flags[9]), .battery_fail_flag_o(flags[10]),
        .main_reg_overcurrent_lowpower_flag_o(flags[11]), .can_wake_flag_o(flags[12]),
        .can_overtemp_flag_o(flags[13]), .rxd_stuck_low_flag_o(flags[14]),
        .rxd_stuck_high_flag_o(flags[15]), .txd_stuck_dominant_flag_o(flags[16]),
        .bus_dominant_clamp_flag_o(flags[17])
    );

    flag_host u_host (.clk_i(clk_i), .flags_i(flags), .supply_rd_o(srd), .can_rd_o(crd));

    task automatic chk(input logic [17:0] got, input logic [17:0] want);
        checked++;
        if (got !== want) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic hold(input int i, input int n);
        @(posedge clk_i);
        mon[i] <= 1'b1;
        repeat (n) @(posedge clk_i);
        mon[i] <= 1'b0;
    endtask

    task automatic rd(input int i);
        u_host.read_word(i > 11, word);
        #1;
    endtask

    // raise, read while still present, then drop and read again
    task automatic sticky(input int i, input int n);
        @(posedge clk_i);
        mon[i] <= 1'b1;
        settle(n + 4);
        exp_f[i] = 1'b1;
        chk(flags, exp_f);
        rd(i);
        chk(18'(word[i]), 18'h00001);
        chk(flags, exp_f);
        @(posedge clk_i);
        mon[i] <= 1'b0;
        settle(4);
        rd(i);
        chk(18'(word[i]), 18'h00001);
        exp_f[i] = 1'b0;
        chk(flags, exp_f);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        rst_i   = 1'b1;
        ce      = 1'b1;
        mon     = 18'h00000;
        norm    = 1'b0;
        lpm     = 1'b0;
        exp_f   = 18'h00000;
        n_fail  = 0;
        checked = 0;
        settle(19);
        chk(flags, exp_f);
        @(posedge clk_i);
        rst_i <= 1'b0;
        hold(7, F + 4);
        hold(11, F + 4);
        settle(4);
        chk(flags, exp_f);
        @(posedge clk_i);
        norm <= 1'b1;
        lpm  <= 1'b1;
        foreach (filt[k]) begin
            hold(filt[k], F - 1);
            hold(filt[k], F - 1);
            settle(4);
            chk(flags, exp_f);
        end
        foreach (filt[k]) sticky(filt[k], F + 2);
        foreach (dir[k]) sticky(dir[k], 0);
        hold(17, D - 10);
        settle(4);
        chk(flags, exp_f);
        sticky(17, D + 2);
        @(posedge clk_i);
        mon[12] <= 1'b1;
        settle(6);
        exp_f[12] = 1'b1;
        chk(flags, exp_f);
        rd(12);
        exp_f[12] = 1'b0;
        chk(flags, exp_f);
        @(posedge clk_i);
        mon[12] <= 1'b0;
        settle(4);
        chk(flags, exp_f);
        hold(9, 10);
        settle(8);
        exp_f[9] = 1'b1;
        chk(flags, exp_f);
        rd(9);
        exp_f[9] = 1'b0;
        chk(flags, exp_f);
        hold(9, R + 10);
        settle(8);
        chk(flags, exp_f);
        // ce low freezes the synchronisers, so a fault inside it is never seen
        @(posedge clk_i);
        ce <= 1'b0;
        hold(10, 6);
        settle(4);
        chk(flags, exp_f);
        @(posedge clk_i);
        ce <= 1'b1;
        settle(4);
        chk(flags, exp_f);
        hold(2, 6);
        settle(4);
        exp_f[2] = 1'b1;
        chk(flags, exp_f);
        @(posedge clk_i);
        rst_i <= 1'b1;
        settle(2);
        exp_f = 18'h00000;
        chk(flags, exp_f);
        @(posedge clk_i);
        rst_i <= 1'b0;
        settle(4);
        // reset pin synchroniser starts high: no false short pulse after release
        chk(flags, exp_f);
        print_verdict;
    end
endmodule // supply_can_diag_flags_tb
